// ==== lpm_pkg.sv ====
// Package of constants and types for the low power mode controller
package lpm_pkg;

  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned FREQ_W          = 16;
  // Frequencies in units of 100 kHz
  localparam logic [15:0] F_RANGE1_MAX    = 16'h0140;
  localparam logic [15:0] F_RANGE2_MAX    = 16'h00A0;
  localparam logic [15:0] F_RANGE3_MAX    = 16'h002A;
  localparam logic [15:0] F_R1_WS_LIMIT   = 16'h00A0;
  localparam logic [15:0] F_R2_WS_LIMIT   = 16'h0050;
  // Wake times, ns and CPU cycles
  localparam int unsigned T_STANDBY_NS    = 60000;
  localparam int unsigned T_STANDBY_TYP_NS = 65000;
  localparam int unsigned T_STOP_NS       = 5000;
  localparam int unsigned T_LPRUN_NS      = 3000;
  localparam int unsigned T_STEP_NS       = 5000;
  localparam int unsigned SLEEP_CYC       = 6;
  localparam int unsigned LPSLEEP_CYC     = 7;
  localparam int unsigned CNT_W           = 13;
  // Longest times round down, shortest round up
  localparam logic [12:0] STANDBY_CYC =
    13'((T_STANDBY_NS * CLK_MHZ) / 1000);
  localparam logic [12:0] STOP_CYC    = 13'((T_STOP_NS * CLK_MHZ) / 1000);
  localparam logic [12:0] LPRUN_CYC   = 13'((T_LPRUN_NS * CLK_MHZ) / 1000);
  localparam logic [12:0] STEP_CYC    =
    13'((T_STEP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [12:0] SLEEP_CNT   = 13'(SLEEP_CYC);
  localparam logic [12:0] LPSLEEP_CNT = 13'(LPSLEEP_CYC);

  typedef enum logic [2:0] {
    MODE_RUN     = 3'h0,
    MODE_SLEEP   = 3'h1,
    MODE_LPRUN   = 3'h2,
    MODE_LPSLEEP = 3'h3,
    MODE_STOP    = 3'h4,
    MODE_STANDBY = 3'h5
  } lpm_mode_t;

  typedef enum logic [1:0] {
    RANGE_1 = 2'h1,
    RANGE_2 = 2'h2,
    RANGE_3 = 2'h3
  } lpm_range_t;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'h0,
    ST_LOW    = 2'h1,
    ST_WAKE   = 2'h2
  } lpm_state_t;

  // Requester indices for the fast oscillator
  localparam int unsigned N_REQ     = 3;
  localparam int unsigned REQ_SER   = 0;
  localparam int unsigned REQ_LPSER = 1;
  localparam int unsigned REQ_TWB   = 2;

endpackage : lpm_pkg

// ==== lpm_osc_if.sv ====
// Interface carrying fast oscillator requests and grants
`timescale 1ns/1ns
`default_nettype none
interface lpm_osc_if;
  logic [2:0] req;      // Per-peripheral oscillator request
  logic       in_stop;  // Device is in Stop
  logic       osc_on;   // Fast oscillator enabled
  logic [2:0] gate;     // Per-peripheral clock gate
  modport ctrl (output in_stop, input osc_on, input gate, output req);
  modport arb  (input req, input in_stop, output osc_on, output gate);
endinterface : lpm_osc_if
`default_nettype wire

// ==== lpm_osc_arb.sv ====
// Fast internal oscillator arbiter for Stop mode requests
`timescale 1ns/1ns
`default_nettype none
module lpm_osc_arb (
  input  wire logic core_clk_i,
  input  wire logic reset_n_i,
  input  wire logic run_en_i,
  lpm_osc_if.arb    osc
);
  typedef struct packed {
    logic       on;
    logic [2:0] gate;
  } lpm_arb_t;
  lpm_arb_t s_q;
  lpm_arb_t s_d;

  // In Stop feed only requesters; off when none remain
  always_comb begin
    s_d = s_q;
    if (osc.in_stop) begin
      s_d.on   = |osc.req;
      s_d.gate = osc.req;
    end else begin
      s_d.on   = run_en_i;
      s_d.gate = {3{run_en_i}};
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign osc.osc_on = s_q.on;
  assign osc.gate   = s_q.gate;

  property p_osc_off_idle;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (osc.in_stop && osc.req == 3'h0) |=> !osc.osc_on;
  endproperty
  a_osc_off_idle: assert property (p_osc_off_idle)
    else $error("fast osc on with no request in Stop");

  property p_gate_only_req;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      osc.in_stop ##1 osc.in_stop |-> osc.gate == $past(osc.req);
  endproperty
  a_gate_only_req: assert property (p_gate_only_req)
    else $error("clock gated to a non-requester");
endmodule : lpm_osc_arb
`default_nettype wire

// ==== lpm_freq_chk.sv ====
// Frequency and wait state limits per voltage range
`timescale 1ns/1ns
`default_nettype none
module lpm_freq_chk (
  input  wire logic                   core_clk_i,
  input  wire logic                   reset_n_i,
  input  wire lpm_pkg::lpm_range_t    range_i,
  input  wire logic [15:0]            freq_i,
  output logic                        freq_ok_o,
  output logic                        wait_state_o
);
  typedef struct packed {
    logic ok;
    logic ws;
  } lpm_fc_t;
  lpm_fc_t s_q;
  lpm_fc_t s_d;

  // Limit check and flash wait state per range
  always_comb begin
    s_d = s_q;
    case (range_i)
      lpm_pkg::RANGE_1: begin
        s_d.ok = freq_i <= lpm_pkg::F_RANGE1_MAX;
        s_d.ws = freq_i >  lpm_pkg::F_R1_WS_LIMIT;
      end
      lpm_pkg::RANGE_2: begin
        s_d.ok = freq_i <= lpm_pkg::F_RANGE2_MAX;
        s_d.ws = freq_i >  lpm_pkg::F_R2_WS_LIMIT;
      end
      lpm_pkg::RANGE_3: begin
        s_d.ok = freq_i <= lpm_pkg::F_RANGE3_MAX;
        s_d.ws = 1'b0;
      end
      default: begin
        s_d.ok = 1'b0;
        s_d.ws = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign freq_ok_o    = s_q.ok;
  assign wait_state_o = s_q.ws;

  property p_r3_no_ws;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      range_i == lpm_pkg::RANGE_3 |=> !wait_state_o;
  endproperty
  a_r3_no_ws: assert property (p_r3_no_ws)
    else $error("wait state in range 3");

  property p_r1_ws;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (range_i == lpm_pkg::RANGE_1 && freq_i > lpm_pkg::F_R1_WS_LIMIT)
      |=> wait_state_o;
  endproperty
  a_r1_ws: assert property (p_r1_ws)
    else $error("missing wait state above 16 MHz");
endmodule : lpm_freq_chk
`default_nettype wire

// ==== lpm_ctrl.sv ====
// Low power mode sequencer top
`timescale 1ns/1ns
`default_nettype none
module lpm_ctrl (
  input  wire logic                core_clk_i,
  input  wire logic                reset_n_i,
  input  wire lpm_pkg::lpm_mode_t  mode_req_i,
  input  wire logic                enter_i,
  input  wire logic                fast_osc_run_i,
  input  wire logic                event_line_i,
  input  wire logic                ext_reset_pin_n_i,
  input  wire logic [2:0]          standby_wake_pin_i,
  input  wire logic                ser_start_i,
  input  wire logic                lpser_start_i,
  input  wire logic                lpser_addr_i,
  input  wire logic                ser_addr_i,
  input  wire logic                twb_rx_i,
  input  wire logic                twb_match_i,
  input  wire logic                rtc_en_i,
  input  wire logic                wdog_en_i,
  input  wire lpm_pkg::lpm_range_t range_i,
  input  wire logic [15:0]         freq_i,
  input  wire logic                low_supply_i,
  input  wire logic                freq_step_i,
  output lpm_pkg::lpm_mode_t       mode_o,
  output logic                     core_reg_on_o,
  output logic                     core_reset_n_o,
  output logic                     pll_on_o,
  output logic                     multispeed_osc_on_o,
  output logic                     internal_fast_osc_on_o,
  output logic                     external_fast_osc_on_o,
  output logic                     internal_slow_osc_on_o,
  output logic                     external_slow_crystal_on_o,
  output logic [2:0]               periph_clk_gate_o,
  output logic                     ser_wake_irq_o,
  output logic                     lpser_wake_irq_o,
  output logic                     twb_wake_irq_o,
  output logic                     wake_o,
  output logic                     standby_flag_o,
  output logic                     freq_ok_o,
  output logic                     wait_state_o,
  output logic                     step_ready_o
);
  typedef struct packed {
    lpm_pkg::lpm_state_t st;
    lpm_pkg::lpm_mode_t  mode;
    logic [12:0]         cnt;
    logic [12:0]         step_cnt;
    logic [12:0]         age;
    logic                reg_on;
    logic                core_rst_n;
    logic                fast_osc;
    logic [2:0]          wake_q;
    logic                ser_irq;
    logic                lpser_irq;
    logic                twb_irq;
    logic                wake;
    logic                sb_flag;
  } lpm_top_t;
  lpm_top_t s_q;
  lpm_top_t s_d;

  lpm_osc_if osc ();
  logic        wake_src;
  logic        sb_src;
  logic [12:0] wake_len;

  // Fast oscillator arbitration and range checks
  lpm_osc_arb u_arb (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .run_en_i   (s_q.fast_osc),
    .osc        (osc.arb)
  );

  lpm_freq_chk u_fchk (
    .core_clk_i   (core_clk_i),
    .reset_n_i    (reset_n_i),
    .range_i      (range_i),
    .freq_i       (freq_i),
    .freq_ok_o    (freq_ok_o),
    .wait_state_o (wait_state_o)
  );

  // Requests: receivers needing the fast osc and the two-wire bus
  assign osc.in_stop = (s_q.mode == lpm_pkg::MODE_STOP) &&
                       (s_q.st == lpm_pkg::ST_LOW);
  assign osc.req[lpm_pkg::REQ_SER]   = ser_start_i | ser_addr_i;
  assign osc.req[lpm_pkg::REQ_LPSER] = 1'b0;  // Runs on slow crystal
  assign osc.req[lpm_pkg::REQ_TWB]   = twb_rx_i;

  // Wake sources per mode
  assign sb_src = !ext_reset_pin_n_i |
                  |(standby_wake_pin_i & ~s_q.wake_q);
  assign wake_src = (s_q.mode == lpm_pkg::MODE_STANDBY) ? sb_src :
                    (event_line_i | ser_start_i | lpser_start_i |
                     lpser_addr_i | ser_addr_i | twb_match_i);

  // Wake latency per mode
  always_comb begin
    case (s_q.mode)
      lpm_pkg::MODE_SLEEP:   wake_len = lpm_pkg::SLEEP_CNT;
      lpm_pkg::MODE_LPRUN:   wake_len = lpm_pkg::LPRUN_CYC;
      lpm_pkg::MODE_LPSLEEP: wake_len = lpm_pkg::LPSLEEP_CNT;
      lpm_pkg::MODE_STOP:    wake_len = lpm_pkg::STOP_CYC;
      lpm_pkg::MODE_STANDBY: wake_len = lpm_pkg::STANDBY_CYC;
      default:               wake_len = 13'h0001;
    endcase
  end

  // Sequencer next state
  always_comb begin
    s_d        = s_q;
    s_d.wake   = 1'b0;
    s_d.wake_q = standby_wake_pin_i;
    // Cycles spent waking, watched by the exit time checks
    s_d.age    = (s_q.st == lpm_pkg::ST_WAKE) ? s_q.age + 13'h0001 : 13'h0000;
    if (s_q.step_cnt != 13'h0000) begin
      s_d.step_cnt = s_q.step_cnt - 13'h0001;
    end
    if (freq_step_i && low_supply_i) begin
      s_d.step_cnt = lpm_pkg::STEP_CYC;
    end
    // Receiver and bus wake flags: set wins over clear
    if (s_q.st == lpm_pkg::ST_ACTIVE) begin
      s_d.ser_irq   = 1'b0;
      s_d.lpser_irq = 1'b0;
      s_d.twb_irq   = 1'b0;
    end
    if (osc.in_stop) begin
      if (ser_start_i || ser_addr_i)     s_d.ser_irq   = 1'b1;
      if (lpser_start_i || lpser_addr_i) s_d.lpser_irq = 1'b1;
      if (twb_match_i)                   s_d.twb_irq   = 1'b1;
    end
    case (s_q.st)
      lpm_pkg::ST_ACTIVE: begin
        s_d.core_rst_n = 1'b1;
        s_d.fast_osc   = fast_osc_run_i;
        if (enter_i) begin
          s_d.mode = mode_req_i;
          s_d.st   = (mode_req_i == lpm_pkg::MODE_RUN) ?
                     lpm_pkg::ST_ACTIVE : lpm_pkg::ST_LOW;
          if (mode_req_i == lpm_pkg::MODE_LPRUN ||
              mode_req_i == lpm_pkg::MODE_LPSLEEP ||
              mode_req_i == lpm_pkg::MODE_STOP) begin
            s_d.fast_osc = 1'b0;
          end
          if (mode_req_i == lpm_pkg::MODE_STANDBY) begin
            s_d.reg_on   = 1'b0;
            s_d.fast_osc = 1'b0;
            s_d.core_rst_n = 1'b0;  // Core state is lost
            s_d.sb_flag  = 1'b1;  // Kept in standby domain
          end
        end
      end
      lpm_pkg::ST_LOW: begin
        if (wake_src) begin
          s_d.st  = lpm_pkg::ST_WAKE;
          s_d.cnt = wake_len - 13'h0001;
        end
      end
      lpm_pkg::ST_WAKE: begin
        if (s_q.mode == lpm_pkg::MODE_STANDBY) begin
          s_d.reg_on = 1'b1;
        end
        if (s_q.cnt == 13'h0000) begin
          s_d.st   = lpm_pkg::ST_ACTIVE;
          s_d.mode = lpm_pkg::MODE_RUN;
          s_d.wake = 1'b1;
          s_d.core_rst_n = 1'b1;  // Core restarts from reset
          if (s_q.mode == lpm_pkg::MODE_STANDBY) begin
            s_d.fast_osc = 1'b0;  // Core clocks back at reset
          end
        end else begin
          s_d.cnt = s_q.cnt - 13'h0001;
        end
      end
      default: s_d.st = lpm_pkg::ST_ACTIVE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q            <= '0;
      s_q.st         <= lpm_pkg::ST_ACTIVE;
      s_q.mode       <= lpm_pkg::MODE_RUN;
      s_q.reg_on     <= 1'b1;
      s_q.core_rst_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Oscillator and power outputs
  logic core_off;
  assign core_off = (s_q.mode == lpm_pkg::MODE_STANDBY) ||
                    (s_q.mode == lpm_pkg::MODE_STOP &&
                     s_q.st == lpm_pkg::ST_LOW);
  assign mode_o                 = s_q.mode;
  assign core_reg_on_o          = s_q.reg_on;
  assign core_reset_n_o         = s_q.core_rst_n;
  assign pll_on_o               = !core_off;
  assign multispeed_osc_on_o    = !core_off;
  assign external_fast_osc_on_o = !core_off &&
                                  s_q.mode != lpm_pkg::MODE_LPRUN;
  assign internal_fast_osc_on_o = osc.osc_on;
  // Slow clocks follow RTC and watchdog enables only
  assign internal_slow_osc_on_o     = wdog_en_i;  // Off unless used
  assign external_slow_crystal_on_o = rtc_en_i;
  assign periph_clk_gate_o  = osc.gate;
  assign ser_wake_irq_o     = s_q.ser_irq;
  assign lpser_wake_irq_o   = s_q.lpser_irq;
  assign twb_wake_irq_o     = s_q.twb_irq;
  assign wake_o             = s_q.wake;
  assign standby_flag_o     = s_q.sb_flag;
  assign step_ready_o       = (s_q.step_cnt == 13'h0000);

  property p_standby_off;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (enter_i && s_q.st == lpm_pkg::ST_ACTIVE &&
       mode_req_i == lpm_pkg::MODE_STANDBY)
      |=> !core_reg_on_o && !pll_on_o && !multispeed_osc_on_o;
  endproperty
  a_standby_off: assert property (p_standby_off)
    else $error("standby entry left power or osc on");

  property p_sb_wake_start;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (s_q.st == lpm_pkg::ST_LOW && s_q.mode == lpm_pkg::MODE_STANDBY &&
       !ext_reset_pin_n_i) |=> s_q.st == lpm_pkg::ST_WAKE;
  endproperty
  a_sb_wake_start: assert property (p_sb_wake_start)
    else $error("standby exit not started by reset pin");

  // Long waits are bounded through the wake age counter
  property p_sb_wake_time;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (s_q.st == lpm_pkg::ST_WAKE && s_q.mode == lpm_pkg::MODE_STANDBY)
      |-> s_q.age < lpm_pkg::STANDBY_CYC;
  endproperty
  a_sb_wake_time: assert property (p_sb_wake_time)
    else $error("standby exit too late");

  property p_stop_wake;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (wake_o && $past(s_q.mode) == lpm_pkg::MODE_STOP)
      |-> s_q.age == lpm_pkg::STOP_CYC;
  endproperty
  a_stop_wake: assert property (p_stop_wake)
    else $error("stop wake not at 5 us");

  property p_sleep_wake;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (s_q.st == lpm_pkg::ST_LOW && s_q.mode == lpm_pkg::MODE_SLEEP &&
       event_line_i) |-> ##7 wake_o;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("sleep wake not at 6 cycles");

  property p_lp_no_fast;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (s_q.mode == lpm_pkg::MODE_LPRUN ||
       s_q.mode == lpm_pkg::MODE_LPSLEEP) ##1
      (s_q.mode == lpm_pkg::MODE_LPRUN ||
       s_q.mode == lpm_pkg::MODE_LPSLEEP) |-> !internal_fast_osc_on_o;
  endproperty
  a_lp_no_fast: assert property (p_lp_no_fast)
    else $error("fast osc on in low-power run or sleep");

  property p_ser_irq;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (osc.in_stop && ser_start_i) |=> ser_wake_irq_o;
  endproperty
  a_ser_irq: assert property (p_ser_irq)
    else $error("no wake interrupt on start bit");

  property p_twb_irq;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (osc.in_stop && twb_match_i) |=> twb_wake_irq_o;
  endproperty
  a_twb_irq: assert property (p_twb_irq)
    else $error("no wake interrupt on address match");

  property p_slow_kept;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      rtc_en_i |-> external_slow_crystal_on_o;
  endproperty
  a_slow_kept: assert property (p_slow_kept)
    else $error("rtc clock stopped by low power mode");

  property p_step_gap;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (freq_step_i && low_supply_i) |=> !step_ready_o [*8];
  endproperty
  a_step_gap: assert property (p_step_gap)
    else $error("step ready too early");

  property p_sb_reset;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (s_q.mode == lpm_pkg::MODE_STANDBY && wake_o == 1'b0 &&
       s_q.st == lpm_pkg::ST_LOW) |-> !core_reset_n_o && standby_flag_o;
  endproperty
  a_sb_reset: assert property (p_sb_reset)
    else $error("core not held in reset in standby");

  c_standby: cover property (@(posedge core_clk_i)
    s_q.mode == lpm_pkg::MODE_STANDBY ##1 wake_o);
  c_stop: cover property (@(posedge core_clk_i)
    osc.in_stop && twb_rx_i ##1 internal_fast_osc_on_o);
  c_sleep: cover property (@(posedge core_clk_i)
    s_q.mode == lpm_pkg::MODE_SLEEP ##1 wake_o);
endmodule : lpm_ctrl
`default_nettype wire

// ==== lpm_far_side.sv ====
// Far-side model of the wake pins and the external reset pin
`timescale 1ns/1ns
`default_nettype none
module lpm_far_side (
  input  wire logic [2:0] pin_hold_i,
  input  wire logic       rst_hold_i,
  output logic      [2:0] wake_pin_o,
  output logic            reset_pin_n_o
);
  // Pins idle low on their pull-down; a hold gives the rising edge
  assign wake_pin_o    = pin_hold_i;
  // Reset pin idles high on its pull-up, low while held
  assign reset_pin_n_o = ~rst_hold_i;
endmodule : lpm_far_side
`default_nettype wire

// ==== test_low_power_mode_controller.sv ====
// Self-checking testbench of the low power mode controller
`timescale 1ns/1ns
`default_nettype none
module test_low_power_mode_controller;
  logic clk, rst_n, enter, fast_run, ev, ser_st, lp_st, lp_ad, ser_ad;
  logic twb_rx, twb_m, rtc_en, wd_en, low_sup, step, rst_hold;
  logic [2:0] pin_hold, pins;
  logic rst_pin_n;
  lpm_pkg::lpm_mode_t mreq, mode;
  lpm_pkg::lpm_range_t rng;
  logic [15:0] freq;
  logic reg_on, core_rn, pll, multispeed_osc, ifo, efo, iso, esc, wk, sbf, fok, ws, srdy;
  logic [2:0] gate, irq;
  int miscompares, num_checks;

  lpm_ctrl lpm_ctrl_i (.core_clk_i(clk), .reset_n_i(rst_n),
    .mode_req_i(mreq), .enter_i(enter), .fast_osc_run_i(fast_run),
    .event_line_i(ev), .ext_reset_pin_n_i(rst_pin_n),
    .standby_wake_pin_i(pins), .ser_start_i(ser_st),
    .lpser_start_i(lp_st), .lpser_addr_i(lp_ad), .ser_addr_i(ser_ad),
    .twb_rx_i(twb_rx), .twb_match_i(twb_m), .rtc_en_i(rtc_en),
    .wdog_en_i(wd_en), .range_i(rng), .freq_i(freq),
    .low_supply_i(low_sup), .freq_step_i(step), .mode_o(mode),
    .core_reg_on_o(reg_on), .core_reset_n_o(core_rn), .pll_on_o(pll),
    .multispeed_osc_on_o(multispeed_osc), .internal_fast_osc_on_o(ifo),
    .external_fast_osc_on_o(efo), .internal_slow_osc_on_o(iso),
    .external_slow_crystal_on_o(esc), .periph_clk_gate_o(gate),
    .ser_wake_irq_o(irq[0]), .lpser_wake_irq_o(irq[1]),
    .twb_wake_irq_o(irq[2]), .wake_o(wk), .standby_flag_o(sbf),
    .freq_ok_o(fok), .wait_state_o(ws), .step_ready_o(srdy));
  lpm_far_side lpm_far_side_i (.pin_hold_i(pin_hold),
    .rst_hold_i(rst_hold), .wake_pin_o(pins), .reset_pin_n_o(rst_pin_n));

  // Clock of 100 MHz
  always #5 clk = ~clk;

  // Comparison with report of any mismatch
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Request entry; mode shows one edge after the request is driven
  task automatic go(input lpm_pkg::lpm_mode_t m);
    @(posedge clk);
    mreq  <= m;
    enter <= 1'b1;
    @(posedge clk);
    enter <= 1'b0;
    tick(1);
  endtask : go

  // Count edges from driving a wake source to the wake pulse
  task automatic lat(input string nm, input int l);
    int n;
    n = 0;
    while (wk !== 1'b1 && n < 7000) begin
      tick(1);
      n++;
    end
    chk(nm, 16'(n), 16'(l + 1));
  endtask : lat

  task automatic t_reset;
    chk("mode", mode, lpm_pkg::MODE_RUN);
    chk("reg_on", reg_on, 1'b1);
    chk("core_rn", core_rn, 1'b1);
    chk("flags", {sbf, irq, gate, ifo}, 8'h00);
  endtask : t_reset

  // Short wake latencies, fast oscillator per mode
  task automatic t_short;
    lpm_pkg::lpm_mode_t ms[3];
    int ls[3];
    ms = '{lpm_pkg::MODE_SLEEP, lpm_pkg::MODE_LPRUN, lpm_pkg::MODE_LPSLEEP};
    ls = '{6, 300, 7};
    fast_run <= 1'b1;
    tick(3);
    chk("ifo_run", ifo, 1'b1);
    for (int i = 0; i < 3; i++) begin
      go(ms[i]);
      chk("mode", mode, ms[i]);
      if (i > 0) chk("ifo_lp", ifo, 1'b0);
      ev <= 1'b1;
      lat("wake_lat", ls[i]);
      ev <= 1'b0;
      chk("mode_run", mode, lpm_pkg::MODE_RUN);
    end
    fast_run <= 1'b0;
    go(lpm_pkg::MODE_RUN);
    chk("run_ignored", mode, lpm_pkg::MODE_RUN);
  endtask : t_short

  // Stop: clocks off, slow clocks kept, refusal, event wake
  task automatic t_stop;
    rtc_en <= 1'b1;
    wd_en  <= 1'b1;
    go(lpm_pkg::MODE_STOP);
    chk("stop_osc", {pll, multispeed_osc, efo, ifo}, 4'h0);
    chk("stop_slow", {iso, esc}, 2'h3);
    chk("stop_keep", {reg_on, core_rn}, 2'h3);
    go(lpm_pkg::MODE_SLEEP);
    chk("refused", mode, lpm_pkg::MODE_STOP);
    ev <= 1'b1;
    lat("stop_lat", 500);
    ev <= 1'b0;
    rtc_en <= 1'b0;
    wd_en  <= 1'b0;
  endtask : t_stop

  // Stop: fast oscillator on request only; receiver events also wake
  task automatic t_req;
    go(lpm_pkg::MODE_STOP);
    twb_rx <= 1'b1;
    tick(3);
    chk("twb_osc", {ifo, gate}, 4'hC);
    twb_rx <= 1'b0;
    tick(3);
    chk("osc_off", {ifo, gate}, 4'h0);
    {ser_st, ser_ad, lp_st, lp_ad, twb_m} <= 5'h1F;
    tick(1);
    {ser_st, ser_ad, lp_st, lp_ad, twb_m} <= 5'h00;
    chk("ser_osc", {ifo, gate}, 4'h9);
    tick(1);
    chk("irqs", irq, 3'h7);
    for (int n = 0; n < 700 && wk !== 1'b1; n++) tick(1);
    chk("irq_wake", wk, 1'b1);
    tick(3);
    chk("irq_clr", irq, 3'h0);
  endtask : t_req

  // Standby entry and exit by a wake pin and by the reset pin
  task automatic t_standby(input bit by_pin);
    go(lpm_pkg::MODE_STANDBY);
    chk("sb_off", {reg_on, pll, multispeed_osc, ifo, efo, iso, esc}, 7'h00);
    chk("sb_core_rst", core_rn, 1'b0);
    if (by_pin) pin_hold <= 3'h2;
    else rst_hold <= 1'b1;
    lat("sb_lat", 6000);
    pin_hold <= 3'h0;
    rst_hold <= 1'b0;
    tick(2);
    chk("sb_back", {mode, reg_on, core_rn}, 5'h03);
    chk("sb_flag", sbf, 1'b1);
  endtask : t_standby

  // Frequency limit and wait state per voltage range
  task automatic t_freq;
    lpm_pkg::lpm_range_t r[7];
    logic [15:0] f[7];
    logic [1:0] e[7];
    r = '{lpm_pkg::RANGE_1, lpm_pkg::RANGE_1, lpm_pkg::RANGE_1,
          lpm_pkg::RANGE_2, lpm_pkg::RANGE_2, lpm_pkg::RANGE_3,
          lpm_pkg::RANGE_3};
    f = '{16'h0140, 16'h00A0, 16'h0141, 16'h00A0, 16'h0050,
          16'h002A, 16'h002B};
    e = '{2'h3, 2'h2, 2'h0, 2'h3, 2'h2, 2'h2, 2'h0};
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      rng  <= r[i];
      freq <= f[i];
      tick(2);
      if (e[i][1]) chk("ws", ws, e[i][0]);
      chk("fok", fok, e[i][1]);
    end
  endtask : t_freq

  // Spacing of clock steps at low supply
  task automatic t_step;
    @(posedge clk);
    low_sup <= 1'b1;
    step    <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    tick(10);
    chk("step_busy", srdy, 1'b0);
    tick(500);
    chk("step_ready", srdy, 1'b1);
  endtask : t_step

  initial begin
    {clk, enter, fast_run, ev, ser_st, lp_st, lp_ad, ser_ad} = '0;
    {twb_rx, twb_m, rtc_en, wd_en, low_sup, step, rst_hold} = '0;
    {rst_n, pin_hold, miscompares, num_checks} = '0;
    mreq = lpm_pkg::MODE_RUN;
    rng  = lpm_pkg::RANGE_1;
    freq = 16'h0010;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    t_reset();
    t_short();
    t_stop();
    t_req();
    t_standby(1'b1);
    t_standby(1'b0);
    t_freq();
    t_step();
    tally_and_finish();
  end

  // Watchdog well beyond the expected run of about 14000 cycles
  initial begin
    #400000;
    miscompares++;
    tally_and_finish();
  end
endmodule : test_low_power_mode_controller
`default_nettype wire
